// >>> logic/irq_trap_cfg.svh
// Register offsets, field positions, reset values for the trap and interrupt control block
`ifndef IRQ_TRAP_CFG_SVH
`define IRQ_TRAP_CFG_SVH
`define OFS_CORE_MODE 4'h0
`define OFS_TRAP_STAT 4'h4
`define OFS_GLOBAL_IRQ 4'h8
`define OFS_CPU_STATUS 4'hC
`define BIT_LATENCY_VAR 15
`define BIT_PRIO_HIGH 3
`define BIT_NEST_DIS 15
`define BIT_OVF_A 14
`define BIT_OVF_B 13
`define BIT_CAT_A 12
`define BIT_CAT_B 11
`define BIT_OVF_A_EN 10
`define BIT_OVF_B_EN 9
`define BIT_CAT_EN 8
`define BIT_SHIFT_ERR 7
`define BIT_DIV_ZERO 6
`define BIT_MATH_ERR 4
`define BIT_ADDR_ERR 3
`define BIT_STACK_ERR 2
`define BIT_OSC_FAIL 1
`define BIT_GLOBAL_EN 15
`define BIT_DEFER 14
`define BIT_SW_TRAP 13
`define BIT_ALT_VEC 8
`define TRAP_STAT_MASK 16'hFFDE
`define GLOBAL_IRQ_MASK 16'hE10F
`define GLOBAL_IRQ_RESET 16'h8000
`define CORE_MODE_RESET 16'h0000
`define TRAP_STAT_RESET 16'h0000
`endif

// >>> logic/irq_trap_ctrl.sv
// Interrupt and trap control registers with a classic Wishbone slave
// Contract
// - Core mode bit 15 set selects variable latency, clear selects fixed latency
// - Core mode bit 3 reads one when CPU priority level exceeds seven
// - Four-bit priority level is high bit above status bits 7 to 5
// - Trap status bit 15 disables nesting when set; resets to zero
// - Overflow of accumulator A or B sets flag bit 14 or 13
// - Catastrophic overflow of accumulator A or B sets bit 12 or 11
// - Overflow traps of A and B need enables bit 10 and 9
// - Bit 8 enables catastrophic overflow traps for both accumulators
// - Invalid shift math trap sets bit 7, other math traps clear it
// - Divide-by-zero math trap sets bit 6
// - Any math error trap sets bit 4
// - Address error trap sets bit 3
// - Stack error trap sets bit 2
// - Oscillator failure trap sets bit 1
// - Unimplemented trap status and global control bits read zero
// - Global enable bit 15 resets to one; clear blocks interrupts, not traps
// - Bit 14 reads one while interrupt deferral is active
// - Bit 13 reads one while software trap is enabled
// - Bit 8 set selects alternate vector table, clear the standard one
// - Polarity bits 0 to 3: set means negative edge, clear positive
// - While nesting is disabled, low priority bits are read-only to software
// - While priority high bit is set, all user interrupts are blocked
`timescale 1ns/100ps
`include "irq_trap_cfg.svh"
module irq_trap_ctrl
  import irq_trap_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic WB_ERR_O,
  input wire trap_evt_s TRAP_EVT,
  input wire logic PRIO_HIGH_SET,
  input wire logic PRIO_HIGH_CLR,
  input wire logic CPU_PRIO_WE,
  input wire logic [2:0] CPU_PRIO_IN,
  input wire logic DEFER_ACTIVE,
  input wire logic SW_TRAP_EN,
  input wire logic [3:0] EXT_IRQ_IN,
  input wire logic IRQ_PENDING,
  output core_ctl_s CORE_CTL,
  output logic [3:0] EXT_IRQ_EDGE
);

  logic [15:0] core_mode_r;
  logic [15:0] trap_stat_r;
  logic [15:0] global_irq_r;
  logic [2:0] prio_low_r;
  logic prio_high_r;
  logic [3:0] ext_prev_r;
  logic [31:0] rd_data_nxt;
  logic [15:0] core_view;
  logic [15:0] trap_view;
  logic [15:0] global_view;
  logic [15:0] wdata;
  logic req;
  logic wr_core;
  logic wr_trap;
  logic wr_glob;
  logic wr_stat;
  logic lo_en;
  logic hi_en;
  logic math_evt;
  logic ovf_a_tr;
  logic ovf_b_tr;
  logic cat_a_tr;
  logic cat_b_tr;
  logic [15:0] trap_set;
  logic [15:0] trap_keep;
  logic mapped;

  // Bus decode; a new request only when ack is low
  assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
  assign mapped = (WB_ADR_I == `OFS_CORE_MODE) || (WB_ADR_I == `OFS_TRAP_STAT) ||
                  (WB_ADR_I == `OFS_GLOBAL_IRQ) || (WB_ADR_I == `OFS_CPU_STATUS);
  assign lo_en = WB_SEL_I[0];
  assign hi_en = WB_SEL_I[1];
  assign wdata = WB_DAT_I[15:0];
  assign wr_core = req && mapped && WB_WE_I && (WB_ADR_I == `OFS_CORE_MODE);
  assign wr_trap = req && mapped && WB_WE_I && (WB_ADR_I == `OFS_TRAP_STAT);
  assign wr_glob = req && mapped && WB_WE_I && (WB_ADR_I == `OFS_GLOBAL_IRQ);
  assign wr_stat = req && mapped && WB_WE_I && (WB_ADR_I == `OFS_CPU_STATUS);

  // Qualified trap causes
  assign ovf_a_tr = TRAP_EVT.ovf_a && trap_stat_r[`BIT_OVF_A_EN];
  assign ovf_b_tr = TRAP_EVT.ovf_b && trap_stat_r[`BIT_OVF_B_EN];
  assign cat_a_tr = TRAP_EVT.cat_a && trap_stat_r[`BIT_CAT_EN];
  assign cat_b_tr = TRAP_EVT.cat_b && trap_stat_r[`BIT_CAT_EN];
  assign math_evt = ovf_a_tr || ovf_b_tr || cat_a_tr || cat_b_tr ||
                    TRAP_EVT.shift_err || TRAP_EVT.div_zero;

  // Set vector of trap flags from this cycle's events
  always_comb
  begin
    trap_set = 16'h0000;
    trap_set[`BIT_OVF_A] = ovf_a_tr;
    trap_set[`BIT_OVF_B] = ovf_b_tr;
    trap_set[`BIT_CAT_A] = cat_a_tr;
    trap_set[`BIT_CAT_B] = cat_b_tr;
    trap_set[`BIT_SHIFT_ERR] = TRAP_EVT.shift_err;
    trap_set[`BIT_DIV_ZERO] = TRAP_EVT.div_zero;
    trap_set[`BIT_MATH_ERR] = math_evt;
    trap_set[`BIT_ADDR_ERR] = TRAP_EVT.addr_err;
    trap_set[`BIT_STACK_ERR] = TRAP_EVT.stack_err;
    trap_set[`BIT_OSC_FAIL] = TRAP_EVT.osc_fail;
  end

  // Value kept from register or bus write, byte lanes honoured
  always_comb
  begin
    trap_keep = trap_stat_r;
    if (wr_trap && lo_en)
    begin
      trap_keep[7:0] = wdata[7:0];
    end
    if (wr_trap && hi_en)
    begin
      trap_keep[15:8] = wdata[15:8];
    end
    // Math trap not caused by a shift clears the shift flag
    if (math_evt && !TRAP_EVT.shift_err)
    begin
      trap_keep[`BIT_SHIFT_ERR] = 1'b0;
    end
  end

  // Trap status register; events win over a clear
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      trap_stat_r <= `TRAP_STAT_RESET;
    end
    else
    begin
      trap_stat_r <= (trap_keep | trap_set) & `TRAP_STAT_MASK;
    end
  end

  // Core mode register: latency mode writable
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      core_mode_r <= `CORE_MODE_RESET;
    end
    else if (wr_core && hi_en)
    begin
      core_mode_r[`BIT_LATENCY_VAR] <= wdata[`BIT_LATENCY_VAR];
    end
  end

  // Priority high bit: set by core on trap entry, cleared by core or software
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      prio_high_r <= 1'b0;
    end
    else if (PRIO_HIGH_SET)
    begin
      prio_high_r <= 1'b1;
    end
    else if (PRIO_HIGH_CLR || (wr_core && lo_en && !wdata[`BIT_PRIO_HIGH]))
    begin
      prio_high_r <= 1'b0;
    end
  end

  // Low priority bits: core always, software only while nesting allowed
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      prio_low_r <= 3'h0;
    end
    else if (CPU_PRIO_WE)
    begin
      prio_low_r <= CPU_PRIO_IN;
    end
    else if (wr_stat && lo_en && !trap_stat_r[`BIT_NEST_DIS])
    begin
      prio_low_r <= wdata[7:5];
    end
  end

  // Global control register
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      global_irq_r <= `GLOBAL_IRQ_RESET;
    end
    else
    begin
      if (wr_glob && lo_en)
      begin
        global_irq_r[3:0] <= wdata[3:0];
      end
      if (wr_glob && hi_en)
      begin
        global_irq_r[`BIT_GLOBAL_EN] <= wdata[`BIT_GLOBAL_EN];
        global_irq_r[`BIT_ALT_VEC] <= wdata[`BIT_ALT_VEC];
      end
    end
  end

  // Read views
  always_comb
  begin
    core_view = core_mode_r;
    core_view[`BIT_PRIO_HIGH] = prio_high_r;
    trap_view = trap_stat_r & `TRAP_STAT_MASK;
    global_view = global_irq_r;
    global_view[`BIT_DEFER] = DEFER_ACTIVE;
    global_view[`BIT_SW_TRAP] = SW_TRAP_EN;
    global_view = global_view & `GLOBAL_IRQ_MASK;
  end

  // Read data mux
  always_comb
  begin
    rd_data_nxt = 32'h0000_0000;
    unique case (WB_ADR_I)
      `OFS_CORE_MODE: rd_data_nxt = {16'h0000, core_view};
      `OFS_TRAP_STAT: rd_data_nxt = {16'h0000, trap_view};
      `OFS_GLOBAL_IRQ: rd_data_nxt = {16'h0000, global_view};
      `OFS_CPU_STATUS: rd_data_nxt = {16'h0000, 8'h00, prio_low_r, 5'h00};
      default: rd_data_nxt = 32'h0000_0000;
    endcase
  end

  // Bus answer: ack or err one cycle after request
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      WB_ACK_O <= 1'b0;
      WB_ERR_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end
    else
    begin
      WB_ACK_O <= req && mapped;
      WB_ERR_O <= req && !mapped;
      if (req && mapped && !WB_WE_I)
      begin
        WB_DAT_O <= rd_data_nxt;
      end
    end
  end

  // External line edge detection with polarity select
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      ext_prev_r <= EXT_IRQ_IN; // Track lines so release shows no false edge
      EXT_IRQ_EDGE <= 4'h0;
    end
    else
    begin
      ext_prev_r <= EXT_IRQ_IN;
      EXT_IRQ_EDGE <= (global_irq_r[3:0] & ext_prev_r & ~EXT_IRQ_IN) |
                      (~global_irq_r[3:0] & ~ext_prev_r & EXT_IRQ_IN);
    end
  end

  // Control outputs to the core
  always_comb
  begin
    CORE_CTL.prio_level = {prio_high_r, prio_low_r};
    CORE_CTL.trap_take = |trap_set;
    CORE_CTL.irq_allow = IRQ_PENDING && global_irq_r[`BIT_GLOBAL_EN] && !prio_high_r;
    CORE_CTL.nest_disable = trap_stat_r[`BIT_NEST_DIS];
    CORE_CTL.alt_vectors = global_irq_r[`BIT_ALT_VEC];
    CORE_CTL.var_latency = core_mode_r[`BIT_LATENCY_VAR];
  end

  // Assertions
  flag_sticky_a: assert property (@(posedge CLK) disable iff (!RSTN)
    TRAP_EVT.addr_err |=> trap_stat_r[`BIT_ADDR_ERR])
    else $error("address error flag not set");
  ovf_gate_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (TRAP_EVT.ovf_a && !trap_stat_r[`BIT_OVF_A_EN] && !trap_stat_r[`BIT_OVF_A]
     && !(wr_trap && hi_en)) |=> !trap_stat_r[`BIT_OVF_A])
    else $error("overflow flag set while disabled");
  math_sum_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (TRAP_EVT.div_zero || TRAP_EVT.shift_err) |=> trap_stat_r[`BIT_MATH_ERR])
    else $error("math flag missing");
  reserved_zero_a: assert property (@(posedge CLK) disable iff (!RSTN)
    WB_ACK_O |-> (WB_DAT_O[31:16] == 16'h0000))
    else $error("upper read bits nonzero");
  prio_block_a: assert property (@(posedge CLK) disable iff (!RSTN)
    prio_high_r |-> !CORE_CTL.irq_allow)
    else $error("interrupt allowed at high level");
  nest_lock_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (trap_stat_r[`BIT_NEST_DIS] && !CPU_PRIO_WE) |=> $stable(prio_low_r))
    else $error("priority bits changed while locked");
  global_en_a: assert property (@(posedge CLK) disable iff (!RSTN)
    !global_irq_r[`BIT_GLOBAL_EN] |-> !CORE_CTL.irq_allow)
    else $error("interrupt allowed while disabled");
  ack_pulse_a: assert property (@(posedge CLK) disable iff (!RSTN)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held two cycles");
  edge_neg_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (global_irq_r[0] && $past(EXT_IRQ_IN[0]) && !EXT_IRQ_IN[0] && $stable(global_irq_r[0]))
    |=> EXT_IRQ_EDGE[0])
    else $error("falling edge missed");

  // Bus steps: a request taken, then one answer pulse
  sequence bus_take_s;
    req;
  endsequence

  sequence answer_pulse_s;
    (WB_ACK_O || WB_ERR_O) ##1 !(WB_ACK_O || WB_ERR_O);
  endsequence

  bus_answer_a: assert property (@(posedge CLK) disable iff (!RSTN)
    bus_take_s |=> answer_pulse_s)
    else $error("bus answer not a single pulse");

  // Register reads taken at the core mode, global control and trap status offsets
  sequence core_read_s;
    req && !WB_WE_I && (WB_ADR_I == `OFS_CORE_MODE);
  endsequence

  sequence global_read_s;
    req && !WB_WE_I && (WB_ADR_I == `OFS_GLOBAL_IRQ);
  endsequence

  sequence trap_read_s;
    req && !WB_WE_I && (WB_ADR_I == `OFS_TRAP_STAT);
  endsequence

  // Read data against the state at the taking edge
  prio_view_a: assert property (@(posedge CLK) disable iff (!RSTN)
    core_read_s |=> (WB_DAT_O[`BIT_PRIO_HIGH] == $past(prio_high_r)))
    else $error("priority high bit misread");
  global_view_a: assert property (@(posedge CLK) disable iff (!RSTN)
    global_read_s |=> (WB_DAT_O[`BIT_DEFER] == $past(DEFER_ACTIVE)) &&
      (WB_DAT_O[`BIT_SW_TRAP] == $past(SW_TRAP_EN)))
    else $error("deferral or software trap bit misread");
  global_gap_a: assert property (@(posedge CLK) disable iff (!RSTN)
    global_read_s |=> (WB_DAT_O[12:9] == 4'h0) && (WB_DAT_O[7:4] == 4'h0))
    else $error("unimplemented global bits nonzero");
  trap_gap_a: assert property (@(posedge CLK) disable iff (!RSTN)
    trap_read_s |=> !WB_DAT_O[5] && !WB_DAT_O[0])
    else $error("unimplemented trap bits nonzero");

  // Control outputs and flags one edge after their cause
  latency_out_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (wr_core && hi_en) |=> (CORE_CTL.var_latency == $past(wdata[`BIT_LATENCY_VAR])))
    else $error("latency mode not taken from write");
  div_flag_a: assert property (@(posedge CLK) disable iff (!RSTN)
    TRAP_EVT.div_zero |=> trap_stat_r[`BIT_DIV_ZERO])
    else $error("divide flag not set");
  shift_clear_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (TRAP_EVT.div_zero && !TRAP_EVT.shift_err) |=> !trap_stat_r[`BIT_SHIFT_ERR])
    else $error("shift flag kept after other math trap");
  high_set_a: assert property (@(posedge CLK) disable iff (!RSTN)
    PRIO_HIGH_SET |=> (CORE_CTL.prio_level[3] == 1'b1))
    else $error("priority high bit not set");

  // Reset values, checked one cycle after reset is sampled low
  reset_value_a: assert property (@(posedge CLK)
    !RSTN |=> (trap_stat_r == `TRAP_STAT_RESET) && (global_irq_r == `GLOBAL_IRQ_RESET))
    else $error("control registers not at reset value");

endmodule : irq_trap_ctrl

// >>> logic/irq_trap_pkg.sv
// Types shared by the trap and interrupt control block
package irq_trap_pkg;
  typedef struct packed {
    logic ovf_a;
    logic ovf_b;
    logic cat_a;
    logic cat_b;
    logic shift_err;
    logic div_zero;
    logic addr_err;
    logic stack_err;
    logic osc_fail;
  } trap_evt_s;
  typedef struct packed {
    logic [3:0] prio_level;
    logic trap_take;
    logic irq_allow;
    logic nest_disable;
    logic alt_vectors;
    logic var_latency;
  } core_ctl_s;
endpackage : irq_trap_pkg

// >>> sim/core_src_model.sv
// Behavioural model of the processor core and trap sources
`timescale 1ns/100ps
module core_src_model
  import irq_trap_pkg::*;
(
  input wire logic clk,
  input wire logic [8:0] fire,
  output trap_evt_s evt
);
  // Launch requested trap events one cycle later, as wide as the request
  always_ff @(posedge clk)
  begin
    evt <= trap_evt_s'(fire);
  end
endmodule : core_src_model

// >>> sim/irq_trap_ctrl_tb.sv
// Self-checking bench for the trap and interrupt control registers
`timescale 1ns/100ps
`include "irq_trap_cfg.svh"
module irq_trap_ctrl_tb
  import irq_trap_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [3:0] lanes = 4'h3;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  logic berr;
  logic [8:0] fire = 9'h000;
  trap_evt_s evt;
  logic pset = 1'b0;
  logic pclr = 1'b0;
  logic pwe = 1'b0;
  logic [2:0] pin = 3'h0;
  logic defer = 1'b0;
  logic swt = 1'b0;
  logic pend = 1'b0;
  logic [3:0] ext = 4'h0;
  core_ctl_s ctl;
  logic [3:0] edge_o;
  logic [31:0] q;
  logic last_err;
  int err_total = 0;
  int checked = 0;
  int cyc_cnt = 0;
  // 50 ns clock
  always #25 clk = ~clk;
  irq_trap_ctrl i_irq_trap_ctrl (.CLK(clk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .WB_ERR_O(berr), .TRAP_EVT(evt), .PRIO_HIGH_SET(pset),
    .PRIO_HIGH_CLR(pclr), .CPU_PRIO_WE(pwe), .CPU_PRIO_IN(pin), .DEFER_ACTIVE(defer),
    .SW_TRAP_EN(swt), .EXT_IRQ_IN(ext), .IRQ_PENDING(pend), .CORE_CTL(ctl),
    .EXT_IRQ_EDGE(edge_o));
  core_src_model i_core_src_model (.clk(clk), .fire(fire), .evt(evt));
  task final_report;
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One classic cycle, held until ack or err is sampled
  task wb(input logic w, input logic [3:0] a, input logic [15:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= lanes;
    dat <= {16'h0000, d};
    @(posedge clk);
    while (ack !== 1'b1 && berr !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 20)
      err_total++;
    q = rdat;
    last_err = berr;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask : wb
  task rd(input logic [3:0] a);
    wb(1'b0, a, 16'h0000);
  endtask : rd
  // Pulse trap events and check the same-cycle trap request
  task fire_chk(input logic [8:0] m, input logic take);
    fire <= m;
    @(posedge clk);
    fire <= 9'h000;
    @(posedge clk);
    chk({31'h0000_0000, ctl.trap_take}, {31'h0000_0000, take});
  endtask : fire_chk
  task edge_chk(input logic [3:0] v, input logic [3:0] exp);
    ext <= v;
    @(posedge clk);
    @(posedge clk);
    chk(32'(edge_o), 32'(exp));
  endtask : edge_chk
  // Hang guard
  always @(posedge clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 3000)
    begin
      err_total++;
      final_report;
    end
  end
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(`OFS_CORE_MODE); chk(q, 32'h0000_0000);
    rd(`OFS_TRAP_STAT); chk(q, 32'h0000_0000);
    rd(`OFS_GLOBAL_IRQ); chk(q, 32'h0000_8000);
    wb(1'b1, `OFS_TRAP_STAT, 16'hFFFF);
    rd(`OFS_TRAP_STAT); chk(q, 32'h0000_FFDE);
    chk(32'(ctl.nest_disable), 32'h0000_0001);
    wb(1'b1, `OFS_TRAP_STAT, 16'h0000);
    fire_chk(9'h1E0, 1'b0);
    rd(`OFS_TRAP_STAT); chk(q & 32'h0000_FFEF, 32'h0000_0000);
    wb(1'b1, `OFS_TRAP_STAT, 16'h0700);
    fire_chk(9'h120, 1'b1);
    rd(`OFS_TRAP_STAT); chk(q & 32'h0000_FFEF, 32'h0000_4F00);
    fire_chk(9'h0C0, 1'b1);
    rd(`OFS_TRAP_STAT); chk(q & 32'h0000_FFEF, 32'h0000_7F00);
    wb(1'b1, `OFS_TRAP_STAT, 16'h0000);
    fire_chk(9'h010, 1'b1);
    rd(`OFS_TRAP_STAT); chk(q, 32'h0000_0090);
    fire_chk(9'h008, 1'b1);
    rd(`OFS_TRAP_STAT); chk(q, 32'h0000_0050);
    fire_chk(9'h007, 1'b1);
    rd(`OFS_TRAP_STAT); chk(q, 32'h0000_005E);
    wb(1'b1, `OFS_TRAP_STAT, 16'h0040);
    rd(`OFS_TRAP_STAT); chk(q, 32'h0000_0040);
    wb(1'b1, `OFS_GLOBAL_IRQ, 16'hFFFF);
    rd(`OFS_GLOBAL_IRQ); chk(q, 32'h0000_810F);
    chk(32'(ctl.alt_vectors), 32'h0000_0001);
    defer <= 1'b1;
    swt <= 1'b1;
    @(posedge clk);
    rd(`OFS_GLOBAL_IRQ); chk(q, 32'h0000_E10F);
    edge_chk(4'hF, 4'h0);
    edge_chk(4'h0, 4'hF);
    wb(1'b1, `OFS_GLOBAL_IRQ, 16'h8000);
    chk(32'(ctl.alt_vectors), 32'h0000_0000);
    edge_chk(4'hF, 4'hF);
    wb(1'b1, `OFS_CORE_MODE, 16'h8000);
    rd(`OFS_CORE_MODE); chk(q, 32'h0000_8000);
    chk(32'(ctl.var_latency), 32'h0000_0001);
    pend <= 1'b1;
    pset <= 1'b1;
    pwe <= 1'b1;
    pin <= 3'h5;
    @(posedge clk);
    pset <= 1'b0;
    pwe <= 1'b0;
    @(posedge clk);
    rd(`OFS_CORE_MODE); chk(q, 32'h0000_8008);
    chk(32'(ctl.prio_level), 32'h0000_000D);
    chk(32'(ctl.irq_allow), 32'h0000_0000);
    rd(`OFS_CPU_STATUS); chk(q, 32'h0000_00A0);
    wb(1'b1, `OFS_CORE_MODE, 16'h0008);
    rd(`OFS_CORE_MODE); chk(q, 32'h0000_0008);
    wb(1'b1, `OFS_CORE_MODE, 16'h0000);
    chk(32'(ctl.irq_allow), 32'h0000_0001);
    wb(1'b1, `OFS_GLOBAL_IRQ, 16'h0000);
    chk(32'(ctl.irq_allow), 32'h0000_0000);
    wb(1'b1, `OFS_CPU_STATUS, 16'h0060);
    rd(`OFS_CPU_STATUS); chk(q, 32'h0000_0060);
    wb(1'b1, `OFS_TRAP_STAT, 16'h8000);
    wb(1'b1, `OFS_CPU_STATUS, 16'h00E0);
    rd(`OFS_CPU_STATUS); chk(q, 32'h0000_0060);
    // Core sets then clears the priority high bit
    pset <= 1'b1;
    @(posedge clk);
    pset <= 1'b0;
    pclr <= 1'b1;
    @(posedge clk);
    chk(32'(ctl.prio_level), 32'h0000_000B);
    pclr <= 1'b0;
    @(posedge clk);
    chk(32'(ctl.prio_level), 32'h0000_0003);
    // Mid-run reset with the external lines held high
    rstn <= 1'b0;
    defer <= 1'b0;
    swt <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    chk(32'(edge_o), 32'h0000_0000);
    rd(`OFS_TRAP_STAT); chk(q, 32'h0000_0000);
    rd(`OFS_GLOBAL_IRQ); chk(q, 32'h0000_8000);
    // Low byte lane only: high half must stay
    lanes = 4'h1;
    wb(1'b1, `OFS_GLOBAL_IRQ, 16'h7FFF);
    lanes = 4'h3;
    rd(`OFS_GLOBAL_IRQ); chk(q, 32'h0000_800F);
    rd(4'h2);
    chk({31'h0000_0000, last_err}, 32'h0000_0001);
    final_report;
  end
endmodule : irq_trap_ctrl_tb
